// ### design/lvdc_pkg.sv
// constants for the low-voltage detector control block
package lvdc_pkg;
  localparam logic [15:0] LVDC_CTRL_ADDR = 16'hFFBE;
  localparam logic [15:0] LVDC_LVL_ADDR = 16'hFFBF;
  localparam logic [7:0] LVDC_CTRL_RST = 8'h00;
  localparam logic [3:0] LVDC_LVL_RST = 4'h0;
  localparam int LVDC_EN_BIT = 7;
  localparam int LVDC_SRC_BIT = 2;
  localparam int LVDC_MODE_BIT = 1;
  localparam int LVDC_FLAG_BIT = 0;
  localparam int LVDC_CLK_NS = 8;
  localparam int LVDC_SETTLE_NS = 10000;
  // least time, so rounded up
  localparam int LVDC_SETTLE_CYC = (LVDC_SETTLE_NS + LVDC_CLK_NS - 1)
                                   / LVDC_CLK_NS;
  localparam int LVDC_CNT_W = 11;
endpackage : lvdc_pkg

// ### design/lvdc_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/10ps
module lvdc_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);
  logic meta_ff;
  logic q_ff;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= 1'b0;
      q_ff <= 1'b0;
    end else begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end
  assign o_q = q_ff;
endmodule : lvdc_sync

// ### design/lvdc_top.sv
`timescale 1ns/10ps
module lvdc_top (
  input wire logic I_MCLK,
  input wire logic I_RESET_N,
  input wire logic [15:0] I_ADDR,
  input wire logic I_WR_BYTE,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR_BIT,
  input wire logic [2:0] I_BIT_POS,
  input wire logic I_BIT_VAL,
  input wire logic I_SUPPLY_BELOW,
  input wire logic I_EXT_BELOW,
  input wire logic I_CAUSE_CLR,
  output logic [7:0] O_RDATA,
  output logic [3:0] O_SUPPLY_LEVEL,
  output logic O_CMP_ENABLE,
  output logic O_SOURCE_SEL,
  output logic O_MONITOR_RESET,
  output logic O_MONITOR_IRQ,
  output logic O_RESET_CAUSE,
  output logic O_CMP_SETTLED
);
  import lvdc_pkg::*;

  logic rst_n;
  logic supply_below;
  logic ext_below;
  logic en_ff;
  logic src_ff;
  logic mode_ff;
  logic below_ff;
  logic mon_rst_ff;
  logic irq_ff;
  logic cause_ff;
  logic settled_ff;
  logic [3:0] lvl_ff;
  logic [7:0] rdata_ff;
  logic [LVDC_CNT_W-1:0] settle_cnt_ff;

  lvdc_sync u_rst_sync (
    .i_clk(I_MCLK),
    .i_rst_n(I_RESET_N),
    .i_d(1'b1),
    .o_q(rst_n)
  );
  lvdc_sync u_sup_sync (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_d(I_SUPPLY_BELOW),
    .o_q(supply_below)
  );
  lvdc_sync u_ext_sync (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .i_d(I_EXT_BELOW),
    .o_q(ext_below)
  );

  // register writes are blocked while the detector holds the chip in reset
  wire wr_ok = !mon_rst_ff;
  wire sel_ctrl = (I_ADDR == LVDC_CTRL_ADDR);
  wire sel_lvl = (I_ADDR == LVDC_LVL_ADDR);
  wire byte_ctrl = wr_ok && I_WR_BYTE && sel_ctrl;
  wire bit_ctrl = wr_ok && I_WR_BIT && sel_ctrl;
  wire byte_lvl = wr_ok && I_WR_BYTE && sel_lvl;
  wire bit_lvl = wr_ok && I_WR_BIT && sel_lvl;

  wire nxt_en = byte_ctrl ? I_WDATA[LVDC_EN_BIT] :
                (bit_ctrl && I_BIT_POS == 3'(LVDC_EN_BIT)) ? I_BIT_VAL :
                en_ff;
  wire nxt_src = byte_ctrl ? I_WDATA[LVDC_SRC_BIT] :
                 (bit_ctrl && I_BIT_POS == 3'(LVDC_SRC_BIT)) ? I_BIT_VAL :
                 src_ff;
  wire nxt_mode = byte_ctrl ? I_WDATA[LVDC_MODE_BIT] :
                  (bit_ctrl && I_BIT_POS == 3'(LVDC_MODE_BIT)) ? I_BIT_VAL :
                  mode_ff;

  logic [3:0] lvl_bitwr;
  always_comb begin
    lvl_bitwr = lvl_ff;
    if (!I_BIT_POS[2]) begin
      lvl_bitwr[I_BIT_POS[1:0]] = I_BIT_VAL;
    end
  end
  // upper four bits of the level register are not stored
  wire [3:0] nxt_lvl = mon_rst_ff ? LVDC_LVL_RST :
                       byte_lvl ? I_WDATA[3:0] :
                       bit_lvl ? lvl_bitwr : lvl_ff;

  wire cmp_below = src_ff ? ext_below : supply_below;
  wire nxt_below = en_ff && cmp_below;
  wire nxt_mon_rst = en_ff && mode_ff && below_ff;
  wire nxt_irq = en_ff && !mode_ff && below_ff;
  wire nxt_cause = mon_rst_ff || (cause_ff && !I_CAUSE_CLR);
  wire cnt_done = (settle_cnt_ff == LVDC_CNT_W'(LVDC_SETTLE_CYC));
  wire [LVDC_CNT_W-1:0] nxt_cnt = !en_ff ? '0 :
                                  cnt_done ? settle_cnt_ff :
                                  settle_cnt_ff + 1'b1;

  wire [7:0] ctrl_rd = {en_ff, 4'h0, src_ff, mode_ff, below_ff};
  wire [7:0] nxt_rdata = sel_ctrl ? ctrl_rd :
                         sel_lvl ? {4'h0, lvl_ff} : 8'h00;

  // only the outer reset reaches en, src and mode; a detector reset keeps those but clears lvl_ff and sets cause_ff
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= LVDC_CTRL_RST[LVDC_EN_BIT];
      src_ff <= LVDC_CTRL_RST[LVDC_SRC_BIT];
      mode_ff <= LVDC_CTRL_RST[LVDC_MODE_BIT];
      lvl_ff <= LVDC_LVL_RST;
      cause_ff <= 1'b0;
    end else begin
      en_ff <= nxt_en;
      src_ff <= nxt_src;
      mode_ff <= nxt_mode;
      lvl_ff <= nxt_lvl;
      cause_ff <= nxt_cause;
    end
  end

  // detection path needs only the system clock, so it runs in stop state
  always_ff @(posedge I_MCLK or negedge rst_n) begin
    if (!rst_n) begin
      below_ff <= 1'b0;
      mon_rst_ff <= 1'b0;
      irq_ff <= 1'b0;
      settled_ff <= 1'b0;
      settle_cnt_ff <= '0;
      rdata_ff <= 8'h00;
    end else begin
      below_ff <= nxt_below;
      mon_rst_ff <= nxt_mon_rst;
      irq_ff <= nxt_irq;
      settled_ff <= en_ff && cnt_done;
      settle_cnt_ff <= nxt_cnt;
      rdata_ff <= nxt_rdata;
    end
  end

  assign O_RDATA = rdata_ff;
  assign O_SUPPLY_LEVEL = lvl_ff;
  assign O_CMP_ENABLE = en_ff;
  assign O_SOURCE_SEL = src_ff;
  assign O_MONITOR_RESET = mon_rst_ff;
  assign O_MONITOR_IRQ = irq_ff;
  assign O_RESET_CAUSE = cause_ff;
  assign O_CMP_SETTLED = settled_ff;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!rst_n);

  sequence s_enter_reset;
    en_ff && mode_ff && below_ff;
  endsequence
  sequence s_in_reset;
    mon_rst_ff ##1 mon_rst_ff;
  endsequence

  a_flag_off_disabled: assert property (!en_ff |=> !below_ff)
    else $error("level flag set while detection disabled");
  a_flag_tracks_src: assert property (
    en_ff && src_ff && ext_below |=> below_ff)
    else $error("external source not followed");
  a_reset_hold: assert property (s_enter_reset |=> mon_rst_ff)
    else $error("reset not asserted while below threshold");
  a_no_reset_above: assert property (!below_ff |=> !mon_rst_ff)
    else $error("reset asserted at or above threshold");
  a_irq_from_flag: assert property (
    en_ff && !mode_ff |=> O_MONITOR_IRQ == $past(below_ff))
    else $error("interrupt does not follow level flag");
  a_irq_not_reset: assert property (mode_ff |=> !O_MONITOR_IRQ)
    else $error("interrupt raised in reset response");
  a_cause_set: assert property (mon_rst_ff |=> O_RESET_CAUSE)
    else $error("reset cause not set by detector reset");
  a_keep_ctrl: assert property (
    s_in_reset |-> $stable(en_ff) && $stable(mode_ff)
    && $stable(src_ff))
    else $error("control bits lost during detector reset");
  a_level_clear: assert property (mon_rst_ff |=> lvl_ff == 4'h0)
    else $error("level register not cleared by reset");
  a_byte_write: assert property (
    byte_ctrl |=> en_ff == $past(I_WDATA[7])
    && mode_ff == $past(I_WDATA[1]))
    else $error("byte write not stored");
  a_bit_write: assert property (
    bit_ctrl && !I_WR_BYTE && I_BIT_POS == 3'h7
    |=> en_ff == $past(I_BIT_VAL)
    && $stable(mode_ff))
    else $error("bit write to enable wrong");
  a_rsvd_zero: assert property (sel_ctrl |=> O_RDATA[6:3] == 4'h0)
    else $error("reserved bits read nonzero");
  a_settle_wait: assert property (
    $rose(en_ff) |=> !O_CMP_SETTLED [*8])
    else $error("settled reported too early");
  a_settle_done: assert property (en_ff && cnt_done |=> O_CMP_SETTLED)
    else $error("settled not reported after wait");
  a_settle_early: assert property (!cnt_done |=> !O_CMP_SETTLED)
    else $error("settled reported before count ends");
  a_cause_keep: assert property (
    !mon_rst_ff && !I_CAUSE_CLR |=> $stable(O_RESET_CAUSE))
    else $error("reset cause changed without event");
  a_src_supply: assert property (
    en_ff && !src_ff && supply_below |=> below_ff)
    else $error("supply source not followed");
endmodule : lvdc_top

// ### sim/lvdc_rail_model.sv
// model of the supply rail and external pin comparator levels
`timescale 1ns/10ps
module lvdc_rail_model (
  input wire logic i_clk,
  input wire logic i_sup_low,
  input wire logic i_ext_low,
  output logic o_supply_below,
  output logic o_ext_below
);
  // crossings land 2 ns after each rising edge, clear of the sampling instant
  always @(posedge i_clk) begin
    o_supply_below <= #2 i_sup_low;
    o_ext_below <= #2 i_ext_low;
  end
endmodule : lvdc_rail_model

// ### sim/lvdc_top_tb.sv
// self-checking testbench for the low-voltage detector control block
`timescale 1ns/10ps
module lvdc_top_tb;
  import lvdc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr_byte = 1'b0, wr_bit = 1'b0;
  logic bit_val = 1'b0, sup_low = 1'b0, ext_low = 1'b0, cause_clr = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [2:0] bit_pos = 3'h0;
  logic sup_b, ext_b, cmp_en, src, mrst, irq, cause, settled;
  logic [7:0] rdata;
  logic [3:0] lvl;
  int bad_count = 0, comparisons = 0, cycles = 0;
  always #4 clk = ~clk;
  lvdc_rail_model i_lvdc_rail_model (.i_clk(clk), .i_sup_low(sup_low),
    .i_ext_low(ext_low), .o_supply_below(sup_b), .o_ext_below(ext_b));
  lvdc_top i_lvdc_top (.I_MCLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
    .I_WR_BYTE(wr_byte), .I_WDATA(wdata), .I_WR_BIT(wr_bit),
    .I_BIT_POS(bit_pos), .I_BIT_VAL(bit_val), .I_SUPPLY_BELOW(sup_b),
    .I_EXT_BELOW(ext_b), .I_CAUSE_CLR(cause_clr), .O_RDATA(rdata),
    .O_SUPPLY_LEVEL(lvl), .O_CMP_ENABLE(cmp_en), .O_SOURCE_SEL(src),
    .O_MONITOR_RESET(mrst), .O_MONITOR_IRQ(irq), .O_RESET_CAUSE(cause),
    .O_CMP_SETTLED(settled));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_byte = 1'b1;
    @(negedge clk);
    wr_byte = 1'b0;
  endtask : wr
  task automatic bw(input logic [15:0] a, input logic [2:0] p,
                    input logic v);
    @(negedge clk);
    addr = a;
    bit_pos = p;
    bit_val = v;
    wr_bit = 1'b1;
    @(negedge clk);
    wr_bit = 1'b0;
  endtask : bw
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    cyc(2);
    chk("rdata", e, rdata);
  endtask : rd
  task automatic do_reset();
    rst_n = 1'b0;
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
  endtask : do_reset
  task automatic t_reset_vals();
    rd(LVDC_CTRL_ADDR, LVDC_CTRL_RST);
    rd(LVDC_LVL_ADDR, 8'h00);
    rd(16'hFF00, 8'h00);
  endtask : t_reset_vals
  task automatic t_regs();
    wr(LVDC_CTRL_ADDR, 8'hFB);
    rd(LVDC_CTRL_ADDR, 8'h82);
    chk("reset", 8'h00, {7'h00, mrst});
    wr(LVDC_LVL_ADDR, 8'hFF);
    rd(LVDC_LVL_ADDR, 8'h0F);
    chk("level", 8'h0F, {4'h0, lvl});
    bw(LVDC_LVL_ADDR, 3'h2, 1'b0);
    chk("level", 8'h0B, {4'h0, lvl});
    bw(LVDC_LVL_ADDR, 3'h6, 1'b1);
    rd(LVDC_LVL_ADDR, 8'h0B);
    wr(LVDC_CTRL_ADDR, 8'h00);
  endtask : t_regs
  task automatic t_irq();
    wr(LVDC_CTRL_ADDR, 8'h80);
    chk("enable", 8'h01, {7'h00, cmp_en});
    cyc(LVDC_SETTLE_CYC - 4);
    chk("settled", 8'h00, {7'h00, settled});
    cyc(8);
    chk("settled", 8'h01, {7'h00, settled});
    ext_low = 1'b1;
    cyc(6);
    chk("irq", 8'h00, {7'h00, irq});
    sup_low = 1'b1;
    cyc(6);
    chk("irq", 8'h01, {7'h00, irq});
    rd(LVDC_CTRL_ADDR, 8'h81);
    sup_low = 1'b0;
    cyc(6);
    chk("irq", 8'h00, {7'h00, irq});
  endtask : t_irq
  task automatic t_det_reset();
    bw(LVDC_CTRL_ADDR, 3'h2, 1'b1);
    chk("source", 8'h01, {7'h00, src});
    cyc(6);
    chk("irq", 8'h01, {7'h00, irq});
    bw(LVDC_CTRL_ADDR, 3'h1, 1'b1);
    cyc(4);
    chk("reset", 8'h01, {7'h00, mrst});
    chk("cause", 8'h01, {7'h00, cause});
    wr(LVDC_CTRL_ADDR, 8'h00);
    ext_low = 1'b0;
    cyc(6);
    chk("reset", 8'h00, {7'h00, mrst});
    rd(LVDC_CTRL_ADDR, 8'h86);
    chk("level", 8'h00, {4'h0, lvl});
    cause_clr = 1'b1;
    cyc(2);
    cause_clr = 1'b0;
    chk("cause", 8'h00, {7'h00, cause});
  endtask : t_det_reset
  task automatic t_stop();
    bw(LVDC_CTRL_ADDR, 3'h1, 1'b0);
    bw(LVDC_CTRL_ADDR, 3'h7, 1'b0);
    rd(LVDC_CTRL_ADDR, 8'h04);
    chk("enable", 8'h00, {7'h00, cmp_en});
    wr(LVDC_CTRL_ADDR, 8'h86);
    do_reset();
    rd(LVDC_CTRL_ADDR, 8'h00);
    chk("source", 8'h00, {7'h00, src});
  endtask : t_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    do_reset();
    t_reset_vals();
    t_regs();
    t_irq();
    t_det_reset();
    t_stop();
    final_report();
  end
endmodule : lvdc_top_tb
